// ---- rtl/qpd_decoder.sv ----
// Serial command decoder for four digital pots with setting registers
`timescale 1ns/1ps
`default_nettype none
module qpd_decoder
	import qpd_pkg::*;
#(
	parameter int NV_WRITE_CYC = QPD_NV_WRITE_CYC
) (
	input  wire logic                        clk,
	input  wire logic                        sys_rst,
	input  wire logic                        scl_in,
	input  wire logic                        sda_in,
	output logic                             sda_out,
	output logic                             sda_oe,
	input  wire logic [3:0]                  address_strap_pins,
	input  wire logic                        write_protect_n,
	output logic [QPD_NUM_POTS*QPD_WIDTH-1:0] wiper_position_reg,
	output logic [QPD_NUM_POTS*256-1:0]       tap_select,
	output logic                             nv_busy
);
	if (NV_WRITE_CYC < 1 || NV_WRITE_CYC > QPD_NV_MAX_CYC) begin : g_bad_cyc
		$error("NV_WRITE_CYC out of range");
	end

	logic [2:0] scl_s_q, sda_s_q;
	logic [7:0] nonvolatile_setting_reg [QPD_NUM_POTS*QPD_NUM_REGS];
	logic [7:0] wip_q [QPD_NUM_POTS];
	logic [7:0] nv_data_q [QPD_NUM_POTS];
	logic [3:0] nv_mask_q;
	logic [1:0] nv_reg_q;
	logic       nv_pend_q;
	logic [31:0] nv_cnt_q;
	logic       busy_q;
	qpd_state_e state_q;
	logic [2:0] bit_q;
	logic [7:0] shift_q, tx_q;
	logic [7:0] instr_q;
	logic       ack_phase_q;
	logic       init_q;
	logic       ack_due_q;
	logic       step_arm_q;
	logic       step_up_q;
	logic [1:0] wp_s_q;
	logic [3:0] strap_a_q;
	logic [3:0] strap_b_q;

	// Two-stage synchronisers; stage 2 onward is read by logic
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_s_q   <= 3'h7;
			sda_s_q   <= 3'h7;
			wp_s_q    <= 2'h0;
			strap_a_q <= 4'h0;
			strap_b_q <= 4'h0;
		end else begin
			scl_s_q   <= {scl_s_q[1:0], scl_in};
			sda_s_q   <= {sda_s_q[1:0], sda_in};
			wp_s_q    <= {wp_s_q[0], write_protect_n};
			strap_a_q <= address_strap_pins;
			strap_b_q <= strap_a_q;
		end
	end

	wire scl_rise  = scl_s_q[1] & ~scl_s_q[2];
	wire scl_fall  = ~scl_s_q[1] & scl_s_q[2];
	wire sda_now   = sda_s_q[1];
	wire start_det = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
	wire stop_det  = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];
	wire [7:0] byte_in  = {shift_q[6:0], sda_now};
	wire       counting = state_q == QPD_ADDR || state_q == QPD_INSTR
		|| state_q == QPD_WDATA || state_q == QPD_RDATA;
	wire       byte_end = scl_rise && !ack_phase_q && counting && (bit_q == QPD_BIT_LAST);
	wire [3:0] op       = instr_q[7:4];
	wire [1:0] rsel     = instr_q[3:2];
	wire [1:0] psel     = instr_q[1:0];
	wire [3:0] iop      = byte_in[7:4];
	wire       i_rz     = byte_in[3:2] == QPD_SEL_ZERO;
	wire       i_pz     = byte_in[1:0] == QPD_SEL_ZERO;
	wire       addr_ok  = byte_in[7:4] == QPD_TYPE_ID
		&& byte_in[3:0] == strap_b_q && !busy_q;
	// only recognised encodings are acknowledged and acted on
	wire instr_ok = (iop == QPD_OP_RD_WIPER && i_rz) || (iop == QPD_OP_WR_WIPER && i_rz)
		|| iop == QPD_OP_RD_SET || iop == QPD_OP_WR_SET || iop == QPD_OP_SET2WIP
		|| iop == QPD_OP_WIP2SET || (iop == QPD_OP_G_SET2WIP && i_pz)
		|| (iop == QPD_OP_G_WIP2SET && i_pz) || (iop == QPD_OP_STEP && i_rz);
	wire nv_op   = op == QPD_OP_WR_SET || op == QPD_OP_WIP2SET || op == QPD_OP_G_WIP2SET;
	wire nv_go   = stop_det && nv_pend_q && wp_s_q[1];
	wire ack_ok  = (state_q == QPD_ADDR) ? addr_ok
		: (state_q == QPD_INSTR) ? instr_ok : (state_q == QPD_WDATA);

	// Bit level protocol engine; the acknowledge is driven from the eighth
	// clock fall to the ninth, so data never moves while the clock is high
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q     <= QPD_IDLE;
			bit_q       <= 3'h0;
			shift_q     <= 8'h00;
			tx_q        <= 8'h00;
			instr_q     <= 8'h00;
			ack_due_q   <= 1'b0;
			ack_phase_q <= 1'b0;
			step_arm_q  <= 1'b0;
			step_up_q   <= 1'b0;
			sda_out     <= 1'b0;
			sda_oe      <= 1'b0;
			nv_pend_q   <= 1'b0;
		end else if (start_det) begin
			state_q     <= QPD_ADDR;
			bit_q       <= 3'h0;
			ack_due_q   <= 1'b0;
			ack_phase_q <= 1'b0;
			step_arm_q  <= 1'b0;
			sda_oe      <= 1'b0;
			nv_pend_q   <= 1'b0;
		end else if (stop_det) begin
			state_q     <= QPD_IDLE;
			ack_due_q   <= 1'b0;
			ack_phase_q <= 1'b0;
			step_arm_q  <= 1'b0;
			sda_oe      <= 1'b0;
			nv_pend_q   <= 1'b0;
		end else if (scl_fall) begin
			step_arm_q <= 1'b0;
			if (ack_due_q) begin
				ack_due_q   <= 1'b0;
				ack_phase_q <= 1'b1;
				sda_oe      <= 1'b1;
			end else if (ack_phase_q) begin
				ack_phase_q <= 1'b0;
				bit_q       <= 3'h0;
				sda_oe      <= (state_q == QPD_RDATA) && !tx_q[7];
			end else if (state_q == QPD_RDATA) begin
				tx_q   <= {tx_q[6:0], 1'b0};
				sda_oe <= !tx_q[6];
			end else begin
				sda_oe <= 1'b0;
			end
		end else if (scl_rise && !ack_phase_q) begin
			if (state_q == QPD_STEP) begin
				step_arm_q <= 1'b1;
				step_up_q  <= sda_now;
			end
			if (counting) begin
				shift_q <= byte_in;
				bit_q   <= bit_q + 3'h1;
			end
			if (byte_end) begin
				ack_due_q <= ack_ok;
				case (state_q)
					QPD_ADDR: begin
						state_q <= addr_ok ? QPD_INSTR : QPD_IGNORE;
					end
					QPD_INSTR: begin
						instr_q <= byte_in;
						if (!instr_ok)
							state_q <= QPD_IGNORE;
						else if (iop == QPD_OP_RD_WIPER || iop == QPD_OP_RD_SET)
							state_q <= QPD_RDATA;
						else if (iop == QPD_OP_WR_WIPER || iop == QPD_OP_WR_SET)
							state_q <= QPD_WDATA;
						else if (iop == QPD_OP_STEP)
							state_q <= QPD_STEP;
						else
							state_q <= QPD_DONE;
						nv_pend_q <= instr_ok && (iop == QPD_OP_WIP2SET
							|| iop == QPD_OP_G_WIP2SET);
						tx_q <= (iop == QPD_OP_RD_WIPER) ? wip_q[byte_in[1:0]]
							: nonvolatile_setting_reg[{byte_in[1:0], byte_in[3:2]}];
					end
					QPD_WDATA: begin
						state_q   <= QPD_DONE;
						nv_pend_q <= op == QPD_OP_WR_SET;
					end
					default: begin
						state_q <= QPD_IGNORE;
					end
				endcase
			end
		end
	end

	// Nonvolatile write timer; busy blocks the address acknowledge
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_q    <= 1'b0;
			nv_cnt_q  <= 32'h0;
			nv_mask_q <= 4'h0;
			nv_reg_q  <= 2'h0;
		end else if (nv_go && !busy_q) begin
			busy_q   <= 1'b1;
			nv_cnt_q <= 32'(NV_WRITE_CYC - 1);
			nv_reg_q <= rsel;
			nv_mask_q <= (op == QPD_OP_G_WIP2SET) ? 4'hF : 4'(1 << psel);
		end else if (busy_q) begin
			if (nv_cnt_q == 32'h0) begin
				busy_q    <= 1'b0;
				nv_mask_q <= 4'h0;
			end else begin
				nv_cnt_q <= nv_cnt_q - 32'h1;
			end
		end
	end

	// Wiper and setting storage
	wire commit_wdata = byte_end && !ack_phase_q && state_q == QPD_WDATA
		&& !start_det && !stop_det;
	wire commit_instr = byte_end && !ack_phase_q && state_q == QPD_INSTR
		&& instr_ok && !start_det && !stop_det;
	// A step lands on the fall that ends a full pulse, so the stop never steps
	wire step_pulse   = scl_fall && step_arm_q && state_q == QPD_STEP
		&& !start_det && !stop_det;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			init_q <= 1'b1;
			for (int p = 0; p < QPD_NUM_POTS; p++) begin
				wip_q[p]     <= QPD_SET_RESET;
				nv_data_q[p] <= QPD_SET_RESET;
			end
		end else begin
			init_q <= 1'b0;
			for (int p = 0; p < QPD_NUM_POTS; p++) begin
				if (init_q)
					wip_q[p] <= nonvolatile_setting_reg[p*QPD_NUM_REGS];
				else if (commit_wdata && op == QPD_OP_WR_WIPER && psel == 2'(p))
					wip_q[p] <= byte_in;
				else if (commit_instr && iop == QPD_OP_SET2WIP && byte_in[1:0] == 2'(p))
					wip_q[p] <= nonvolatile_setting_reg[{byte_in[1:0], byte_in[3:2]}];
				else if (commit_instr && iop == QPD_OP_G_SET2WIP)
					wip_q[p] <= nonvolatile_setting_reg[p*QPD_NUM_REGS + int'(byte_in[3:2])];
				else if (step_pulse && psel == 2'(p)) begin
					if (step_up_q && wip_q[p] != QPD_TAP_MAX)
						wip_q[p] <= wip_q[p] + 8'h01;
					else if (!step_up_q && wip_q[p] != QPD_TAP_MIN)
						wip_q[p] <= wip_q[p] - 8'h01;
				end
				if (commit_wdata && op == QPD_OP_WR_SET)
					nv_data_q[p] <= byte_in;
				else if (commit_instr && (iop == QPD_OP_WIP2SET || iop == QPD_OP_G_WIP2SET))
					nv_data_q[p] <= wip_q[p];
			end
		end
	end

	// Setting array, written at the end of the timed write
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < QPD_NUM_POTS*QPD_NUM_REGS; i++)
				nonvolatile_setting_reg[i] <= QPD_SET_RESET;
		end else if (busy_q && nv_cnt_q == 32'h0) begin
			for (int p = 0; p < QPD_NUM_POTS; p++)
				if (nv_mask_q[p])
					nonvolatile_setting_reg[p*QPD_NUM_REGS + int'(nv_reg_q)] <= nv_data_q[p];
		end
	end

	// One-hot tap decode per pot, registered
	genvar g;
	generate
		for (g = 0; g < QPD_NUM_POTS; g++) begin : g_pot
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					wiper_position_reg[g*QPD_WIDTH +: QPD_WIDTH] <= QPD_SET_RESET;
					tap_select[g*256 +: 256] <= 256'h1;
				end else begin
					wiper_position_reg[g*QPD_WIDTH +: QPD_WIDTH] <= wip_q[g];
					tap_select[g*256 +: 256] <= 256'h1 << wip_q[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			nv_busy <= 1'b0;
		else
			nv_busy <= busy_q;
	end
endmodule
`default_nettype wire

// ---- rtl/qpd_pkg.sv ----
// Constants and types for the quad pot serial command decoder
package qpd_pkg;
	localparam logic [3:0] QPD_TYPE_ID      = 4'hC; // Device type code; the value is arbitrary
	localparam int         QPD_NUM_POTS     = 4;
	localparam int         QPD_NUM_REGS     = 4;
	localparam int         QPD_WIDTH        = 8;
	localparam logic [3:0] QPD_OP_RD_WIPER  = 4'h9;
	localparam logic [3:0] QPD_OP_WR_WIPER  = 4'hA;
	localparam logic [3:0] QPD_OP_RD_SET    = 4'hB;
	localparam logic [3:0] QPD_OP_WR_SET    = 4'hC;
	localparam logic [3:0] QPD_OP_SET2WIP   = 4'hD;
	localparam logic [3:0] QPD_OP_WIP2SET   = 4'hE;
	localparam logic [3:0] QPD_OP_G_SET2WIP = 4'h1;
	localparam logic [3:0] QPD_OP_G_WIP2SET = 4'h8;
	localparam logic [3:0] QPD_OP_STEP      = 4'h2;
	localparam logic [1:0] QPD_SEL_ZERO     = 2'h0;
	localparam logic [7:0] QPD_TAP_MAX      = 8'hFF;
	localparam logic [7:0] QPD_TAP_MIN      = 8'h00;
	localparam logic [7:0] QPD_SET_RESET    = 8'h00;
	localparam logic [2:0] QPD_BIT_LAST     = 3'h7;
	localparam int         QPD_CLK_HZ       = 100_000_000;
	localparam int         QPD_NV_WRITE_MS  = 5;
	localparam int         QPD_NV_WRITE_CYC = QPD_CLK_HZ / 1000 * QPD_NV_WRITE_MS;
	localparam int         QPD_NV_MAX_MS    = 10;
	localparam int         QPD_NV_MAX_CYC   = QPD_CLK_HZ / 1000 * QPD_NV_MAX_MS;
	typedef enum logic [2:0] {
		QPD_IDLE,
		QPD_ADDR,
		QPD_INSTR,
		QPD_WDATA,
		QPD_RDATA,
		QPD_DONE,
		QPD_STEP,
		QPD_IGNORE
	} qpd_state_e;
endpackage

// ---- test/qpd_decoder_asserts.sv ----
// Checker for the quad pot serial command decoder
`timescale 1ns/1ps
`default_nettype none
module qpd_decoder_asserts
	import qpd_pkg::*;
#(
	parameter int NV_WRITE_CYC = QPD_NV_WRITE_CYC
) (
	input wire logic          clk,
	input wire logic          sys_rst,
	input wire logic          scl_in,
	input wire logic          sda_in,
	input wire logic          sda_out,
	input wire logic          sda_oe,
	input wire logic [3:0]    address_strap_pins,
	input wire logic          write_protect_n,
	input wire logic [31:0]   wiper_position_reg,
	input wire logic [1023:0] tap_select,
	input wire logic          nv_busy
);
	logic [31:0] busy_cnt_q;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_cnt_q <= 32'h0;
		end else begin
			busy_cnt_q <= nv_busy ? busy_cnt_q + 32'h1 : 32'h0;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence busy_begin_s;
		$rose(nv_busy);
	endsequence
	sequence busy_hold_s;
		nv_busy [*8];
	endsequence
	tap_pot0_a: assert property (tap_select[255:0] == (256'h1 << wiper_position_reg[7:0]))
		else $error("pot 0 tap not at wiper");
	tap_pot3_a: assert property (tap_select[1023:768] == (256'h1 << wiper_position_reg[31:24]))
		else $error("pot 3 tap not at wiper");
	open_drain_a: assert property (sda_oe |-> sda_out == 1'b0)
		else $error("data pin driven high");
	busy_quiet_a: assert property (nv_busy && $past(nv_busy) |-> !sda_oe && $stable(wiper_position_reg))
		else $error("activity during write");
	busy_start_a: assert property (busy_begin_s |-> scl_in && write_protect_n)
		else $error("write began without stop or while protected");
	busy_min_a: assert property (busy_begin_s |-> busy_hold_s)
		else $error("write shorter than minimum");
	busy_max_a: assert property (nv_busy |-> busy_cnt_q < 2 * NV_WRITE_CYC)
		else $error("write too long");
	busy_len_a: assert property ($fell(nv_busy) |-> busy_cnt_q >= NV_WRITE_CYC - 1)
		else $error("write time too short");
	reset_load_a: assert property ($past(sys_rst) |-> wiper_position_reg == 32'h0)
		else $error("wiper not loaded from setting zero");
endmodule
bind qpd_decoder qpd_decoder_asserts #(.NV_WRITE_CYC(NV_WRITE_CYC)) u_chk (
	.clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .address_strap_pins(address_strap_pins),
	.write_protect_n(write_protect_n), .wiper_position_reg(wiper_position_reg),
	.tap_select(tap_select), .nv_busy(nv_busy));
`default_nettype wire

// ---- test/qpd_master_model.sv ----
// Two-wire bus master model with open-drain data
`timescale 1ns/1ps
`default_nettype none
module qpd_master_model (
	input  wire logic clk,
	input  wire logic sda_wire,
	output logic      scl,
	output logic      sda_rel
);
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	task automatic half();
		repeat (4) @(posedge clk);
	endtask
	task automatic bit_io(input logic b, output logic r);
		@(posedge clk) sda_rel <= b;
		repeat (3) @(posedge clk);
		scl <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk) r = sda_wire;
		@(posedge clk) scl <= 1'b0;
	endtask
	task automatic start();
		@(posedge clk) sda_rel <= 1'b1;
		half();
		scl <= 1'b1;
		half();
		sda_rel <= 1'b0;
		half();
		scl <= 1'b0;
	endtask
	task automatic stop();
		@(posedge clk) sda_rel <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		sda_rel <= 1'b1;
		half();
	endtask
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack_n);
		for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
		bit_io(1'b1, ack_n);
	endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the quad pot serial command decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import qpd_pkg::*;
	localparam int         NV  = 300;
	localparam logic [7:0] DEV = {QPD_TYPE_ID, 4'hA};
	logic          clk;
	logic          sys_rst;
	logic          scl;
	logic          m_sda;
	logic          sda_out;
	logic          sda_oe;
	logic          wp_n;
	logic          nv_busy;
	logic [3:0]    straps;
	logic [31:0]   wipers;
	logic [1023:0] taps;
	logic [7:0]    rx;
	logic          a;
	int            error_cnt;
	int            n_compared;
	wire logic     sda_w;
	assign sda_w = m_sda & (sda_oe ? sda_out : 1'b1);
	initial clk = 1'b0;
	always #5 clk = ~clk;
	qpd_decoder #(.NV_WRITE_CYC(NV)) u_dut (.clk(clk), .sys_rst(sys_rst), .scl_in(scl),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .address_strap_pins(straps),
		.write_protect_n(wp_n), .wiper_position_reg(wipers), .tap_select(taps),
		.nv_busy(nv_busy));
	qpd_master_model u_m (.clk(clk), .sda_wire(sda_w), .scl(scl), .sda_rel(m_sda));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] ins, input logic [7:0] dat, input int nb, input logic nak);
		u_m.start();
		u_m.xfer(DEV, rx, a);
		chk({7'h00, a}, 8'h00);
		u_m.xfer(ins, rx, a);
		chk({7'h00, a}, {7'h00, nak});
		if (nb == 1) begin
			u_m.xfer(dat, rx, a);
			chk({7'h00, a}, {7'h00, nak});
		end
		if (nb == 2) u_m.xfer(8'hFF, rx, a);
		u_m.stop();
	endtask
	task automatic settle(input logic first_nak);
		u_m.start();
		u_m.xfer(DEV, rx, a);
		chk({7'h00, a}, {7'h00, first_nak});
		for (int i = 0; i < 20 && a !== 1'b0; i++) begin
			u_m.start();
			u_m.xfer(DEV, rx, a);
		end
		chk({7'h00, a}, 8'h00);
		u_m.stop();
	endtask
	task automatic report_and_stop();
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		sys_rst = 1'b1;
		straps = 4'hA;
		wp_n = 1'b1;
		error_cnt = 0;
		n_compared = 0;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		for (int p = 0; p < 4; p++) begin
			chk(wipers[p*8 +: 8], QPD_SET_RESET);
			cmd({QPD_OP_WR_WIPER, 2'b00, 2'(p)}, 8'h10 + 8'(p), 1, 1'b0);
			chk(wipers[p*8 +: 8], 8'h10 + 8'(p));
			cmd({QPD_OP_RD_WIPER, 2'b00, 2'(p)}, 8'h00, 2, 1'b0);
			chk(rx, 8'h10 + 8'(p));
		end
		u_m.start();
		u_m.xfer({~QPD_TYPE_ID, 4'hA}, rx, a);
		chk({7'h00, a}, 8'h01);
		u_m.start();
		u_m.xfer({QPD_TYPE_ID, 4'h5}, rx, a);
		chk({7'h00, a}, 8'h01);
		u_m.stop();
		cmd({QPD_OP_WR_SET, 2'd2, 2'd1}, 8'hA5, 1, 1'b0);
		settle(1'b1);
		cmd({QPD_OP_RD_SET, 2'd2, 2'd1}, 8'h00, 2, 1'b0);
		chk(rx, 8'hA5);
		cmd({QPD_OP_SET2WIP, 2'd2, 2'd1}, 8'h00, 0, 1'b0);
		chk(wipers[15:8], 8'hA5);
		cmd({QPD_OP_WIP2SET, 2'd3, 2'd0}, 8'h00, 0, 1'b0);
		settle(1'b1);
		cmd({QPD_OP_G_SET2WIP, 2'd3, 2'd0}, 8'h00, 0, 1'b0);
		chk(wipers[7:0], 8'h10);
		chk(wipers[31:24] | wipers[23:16] | wipers[15:8], 8'h00);
		cmd({QPD_OP_G_WIP2SET, 2'd1, 2'd0}, 8'h00, 0, 1'b0);
		settle(1'b1);
		cmd({QPD_OP_RD_SET, 2'd1, 2'd0}, 8'h00, 2, 1'b0);
		chk(rx, 8'h10);
		cmd({QPD_OP_G_SET2WIP, 2'd2, 2'd1}, 8'h00, 0, 1'b1);
		cmd({4'h3, 4'h1}, 8'h00, 0, 1'b1);
		chk(wipers[15:8], 8'h00);
		wp_n <= 1'b0;
		cmd({QPD_OP_WR_SET, 2'd0, 2'd3}, 8'h77, 1, 1'b0);
		settle(1'b0);
		wp_n <= 1'b1;
		cmd({QPD_OP_RD_SET, 2'd0, 2'd3}, 8'h00, 2, 1'b0);
		chk(rx, QPD_SET_RESET);
		cmd({QPD_OP_WR_WIPER, 2'b00, 2'd2}, 8'hFE, 1, 1'b0);
		u_m.start();
		u_m.xfer(DEV, rx, a);
		u_m.xfer({QPD_OP_STEP, 2'b00, 2'd2}, rx, a);
		chk({7'h00, a}, 8'h00);
		repeat (3) u_m.bit_io(1'b1, a);
		chk(wipers[23:16], QPD_TAP_MAX);
		repeat (2) u_m.bit_io(1'b0, a);
		u_m.stop();
		chk(wipers[23:16], 8'hFD);
		report_and_stop();
	end
	initial begin
		#200_000;
		error_cnt++;
		report_and_stop();
	end
endmodule
`default_nettype wire
